// [rtl/sbt_pkg.sv]
// package of register map, field layout and timing constants for the timer
package sbt_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_GLOBAL_IRQ = 10'h00B;
  localparam logic [9:0] IDX_IRQ_FLAGS = 10'h00C;
  localparam logic [9:0] IDX_COUNT_LOW = 10'h00E;
  localparam logic [9:0] IDX_COUNT_HIGH = 10'h00F;
  localparam logic [9:0] IDX_CONTROL = 10'h010;
  localparam logic [9:0] IDX_IRQ_ENABLES = 10'h08C;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h020;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h021;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_OSC_BIT = 3;
  localparam int CTRL_PS_LO_BIT = 4;
  localparam int CTRL_PS_HI_BIT = 5;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam int OVF_BIT = 0;

  // ----------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_GLOBAL = 8'h00;
  localparam logic RESET_FLAG = 1'b0;
  localparam logic RESET_ENABLE = 1'b0;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hB;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int INTERNAL_DIV = 4;

endpackage

// [rtl/sbt_prescaler.sv]
// tick generator: clock source choice, edge detect and prescaler
`timescale 1ns/100ps
module sbt_prescaler
#(
  parameter int INT_DIV = sbt_pkg::INTERNAL_DIV
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic ext_select_i,
  input wire logic ext_clk_i,
  input wire logic [1:0] prescale_i,
  input wire logic restart_i,
  output logic tick_o
);
  import sbt_pkg::*;

  logic [7:0] div_cnt;
  logic ext_q;
  logic [2:0] ps_cnt;
  logic src_pulse;
  logic [2:0] ps_max;

  // internal source is an enable pulse every INT_DIV system clocks (a quarter rate at the default of 4)
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 8'h00;
    end else if (div_cnt == 8'(INT_DIV - 1)) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_clk_i;
    end
  end

  always_comb begin
    if (ext_select_i) begin
      src_pulse = ext_clk_i & ~ext_q;
    end else begin
      src_pulse = (div_cnt == 8'(INT_DIV - 1));
    end
    ps_max = 3'((1 << prescale_i) - 1);
  end

  // prescaler restarts on count writes so a written value lasts a full period
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ps_cnt <= 3'h0;
    end else if (restart_i || !run_i) begin
      ps_cnt <= 3'h0;
    end else if (src_pulse) begin
      if (ps_cnt >= ps_max) begin
        ps_cnt <= 3'h0;
      end else begin
        ps_cnt <= ps_cnt + 3'h1;
      end
    end
  end

  assign tick_o = run_i & src_pulse & (ps_cnt >= ps_max);

endmodule

// [rtl/sbt_timer.sv]
// sixteen bit timer with event reset, overflow interrupt and AXI4-Lite slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
// Notes on behaviour
// - oscillator enable output follows the oscillator enable control bit only.
// - oscillator enable is not gated by sleep; the counter keeps its source.
// - count is a low byte and a high byte, both readable and writable.
// - count increments up to all ones, then wraps to zero.
// - wrap sets the sticky overflow flag until software clears it.
// - interrupt output rises only when the overflow enable bit is set.
// - in special trigger mode a match clears count and requests conversion.
// - trigger clear never sets the overflow flag.
// - trigger clear is suppressed in unsynchronized external counting.
// - a count write in the same cycle as a trigger clear wins.
// - in special trigger mode the compare pair acts as period.
module sbt_timer
#(
  parameter int ADDR_W = 12,
  parameter int INT_DIV = sbt_pkg::INTERNAL_DIV
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ext_clk_i,
  input wire logic [3:0] compare_mode_field_i,
  input wire logic [15:0] compare_register_pair_i,
  input wire logic adc_enable_i,
  output logic osc_enable_o,
  output logic conv_request_o,
  output logic irq_o
);
  import sbt_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] timer_control;
  logic [7:0] global_interrupt_control;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [15:0] count;
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [9:0] wr_idx;
  logic wr_ok;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_low, wr_high, wr_count, wr_ctrl, wr_flags, wr_clear;
  logic tick, special_mode, unsync_ext, match, trig_clear, ovf_event;

  function automatic logic [9:0] index_of(input logic [ADDR_W-1:0] addr);
    index_of = 10'(addr >> 2);
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    mapped = (idx == IDX_GLOBAL_IRQ) || (idx == IDX_IRQ_FLAGS) ||
             (idx == IDX_COUNT_LOW) || (idx == IDX_COUNT_HIGH) ||
             (idx == IDX_CONTROL) || (idx == IDX_IRQ_ENABLES) ||
             (idx == IDX_IRQ_CLEAR) || (idx == IDX_IRQ_STATUS);
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  // address and data are taken in either order; the write fires once both
  // are held, and the slot reopens only after the response is taken
  assign wr_fire = !aw_rdy && !w_rdy && !s_axi_bvalid_o;
  assign wr_idx = index_of(aw_addr_q);
  assign wr_ok = mapped(wr_idx) && (wr_idx != IDX_IRQ_STATUS);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_rdy <= 1'b1;
      aw_addr_q <= '0;
    end else if (aw_rdy && s_axi_awvalid_i) begin
      aw_rdy <= 1'b0;
      aw_addr_q <= s_axi_awaddr_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      aw_rdy <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_rdy <= 1'b1;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (w_rdy && s_axi_wvalid_i) begin
      w_rdy <= 1'b0;
      wdata_q <= s_axi_wdata_i;
      wstrb_q <= s_axi_wstrb_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      w_rdy <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  assign s_axi_awready_o = aw_rdy;
  assign s_axi_wready_o = w_rdy;

  // only the low byte lane carries register data
  always_comb begin
    wr_low = wr_fire && wstrb_q[0] && (wr_idx == IDX_COUNT_LOW);
    wr_high = wr_fire && wstrb_q[0] && (wr_idx == IDX_COUNT_HIGH);
    wr_count = wr_low || wr_high;
    wr_ctrl = wr_fire && wstrb_q[0] && (wr_idx == IDX_CONTROL);
    wr_flags = wr_fire && wstrb_q[0] && (wr_idx == IDX_IRQ_FLAGS);
    wr_clear = wr_fire && wstrb_q[0] && (wr_idx == IDX_IRQ_CLEAR);
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  always_comb begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    unique case (index_of(s_axi_araddr_i))
      IDX_GLOBAL_IRQ: rd_data[7:0] = global_interrupt_control;
      IDX_IRQ_FLAGS: rd_data[OVF_BIT] = overflow_flag;
      IDX_IRQ_STATUS: rd_data[OVF_BIT] = overflow_flag;
      IDX_COUNT_LOW: rd_data[7:0] = count[7:0];
      IDX_COUNT_HIGH: rd_data[7:0] = count[15:8];
      IDX_CONTROL: rd_data[7:0] = timer_control & CTRL_MASK;
      IDX_IRQ_ENABLES: rd_data[OVF_BIT] = overflow_irq_enable;
      IDX_IRQ_CLEAR: rd_data = 32'h00000000;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ar_rdy <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (ar_rdy && s_axi_arvalid_i) begin
      ar_rdy <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_data;
      s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      ar_rdy <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end

  assign s_axi_arready_o = ar_rdy;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_control <= RESET_CONTROL;
    end else if (wr_ctrl) begin
      timer_control <= wdata_q[7:0] & CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      global_interrupt_control <= RESET_GLOBAL;
    end else if (wr_fire && wstrb_q[0] && wr_idx == IDX_GLOBAL_IRQ) begin
      global_interrupt_control <= wdata_q[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_irq_enable <= RESET_ENABLE;
    end else if (wr_fire && wstrb_q[0] && wr_idx == IDX_IRQ_ENABLES) begin
      overflow_irq_enable <= wdata_q[OVF_BIT];
    end
  end

  // sleep has no say here: the oscillator runs whenever its bit is set
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_enable_o <= 1'b0;
    end else begin
      osc_enable_o <= timer_control[CTRL_OSC_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  sbt_prescaler #(
    .INT_DIV(INT_DIV)
  ) u_prescaler (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(timer_control[CTRL_ON_BIT]),
    .ext_select_i(timer_control[CTRL_SRC_BIT]),
    .ext_clk_i(ext_clk_i),
    .prescale_i(timer_control[CTRL_PS_HI_BIT:CTRL_PS_LO_BIT]),
    .restart_i(wr_count || wr_ctrl),
    .tick_o(tick)
  );

  // an unsynchronized external count is not trusted to take the clear
  always_comb begin
    special_mode = (compare_mode_field_i == CMP_MODE_SPECIAL);
    unsync_ext = timer_control[CTRL_SRC_BIT] &&
                 timer_control[CTRL_SYNC_BIT];
    match = special_mode && (count == compare_register_pair_i);
    trig_clear = match && !unsync_ext && !wr_count;
    ovf_event = tick && (count == COUNT_ALL_ONES) &&
                !wr_count && !trig_clear;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= RESET_COUNT;
    end else if (wr_count) begin
      count[7:0] <= wr_low ? wdata_q[7:0] : count[7:0];
      count[15:8] <= wr_high ? wdata_q[7:0] : count[15:8];
    end else if (trig_clear) begin
      count <= RESET_COUNT;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_request_o <= 1'b0;
    end else begin
      conv_request_o <= match && adc_enable_i;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------
  // a wrap in the same cycle as a clear keeps the flag set
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_flag <= RESET_FLAG;
    end else if (ovf_event) begin
      overflow_flag <= 1'b1;
    end else if (wr_clear && wdata_q[OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end else if (wr_flags) begin
      overflow_flag <= wdata_q[OVF_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= overflow_flag && overflow_irq_enable;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_osc_follows;
    wr_ctrl && wdata_q[CTRL_OSC_BIT] |-> ##2 osc_enable_o;
  endproperty
  a_osc_follows: assert property (p_osc_follows)
    else $error("oscillator enable did not follow control bit");
  property p_osc_no_drop;
    $fell(osc_enable_o) |-> $past(!timer_control[CTRL_OSC_BIT]);
  endproperty
  a_osc_no_drop: assert property (p_osc_no_drop)
    else $error("oscillator stopped without control bit clear");
  property p_low_write;
    wr_low |=> count[7:0] == $past(wdata_q[7:0]);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low byte write not stored");
  property p_increment;
    tick && !wr_count && !trig_clear |=> count == $past(count) + 16'h0001;
  endproperty
  a_increment: assert property (p_increment)
    else $error("count did not increment by one");
  property p_flag_sticky;
    ovf_event ##1 (!wr_clear && !wr_flags)[*2] |-> overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag not held");
  property p_irq_masked;
    irq_o |-> $past(overflow_irq_enable && overflow_flag);
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised while masked");
  property p_trigger;
    trig_clear |=> count == RESET_COUNT &&
      conv_request_o == $past(adc_enable_i);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("special trigger did not clear and request");
  property p_no_flag_on_trigger;
    trig_clear && !overflow_flag && !wr_flags |=> !overflow_flag;
  endproperty
  a_no_flag_on_trigger: assert property (p_no_flag_on_trigger)
    else $error("trigger clear set overflow flag");
  property p_unsync_hold;
    match && unsync_ext && !wr_count && !tick |=> $stable(count);
  endproperty
  a_unsync_hold: assert property (p_unsync_hold)
    else $error("unsynchronized count was cleared");
  property p_write_wins;
    wr_high && match |=> count[15:8] == $past(wdata_q[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("trigger clear overrode a count write");
  property p_period;
    special_mode && !unsync_ext && !wr_count &&
      count == compare_register_pair_i |=> count == RESET_COUNT;
  endproperty
  a_period: assert property (p_period)
    else $error("count did not restart at compare pair");
  property p_off_hold;
    !timer_control[CTRL_ON_BIT] && !wr_count && !trig_clear |=> $stable(count);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("count moved while timer off");

  c_wrap: cover property (ovf_event ##1 overflow_flag);
  c_trigger: cover property (trig_clear ##1 conv_request_o);
  c_irq: cover property ($rose(irq_o));
  c_collide: cover property (wr_count && match);

endmodule

// [sim/sbt_far_model.sv]
// far side model: compare unit outputs and external count clock
`timescale 1ns/100ps
module sbt_far_model (
  input wire logic sys_clk_i,
  output logic [3:0] compare_mode_field_o,
  output logic [15:0] compare_register_pair_o,
  output logic adc_enable_o,
  output logic ext_clk_o
);
  initial begin
    compare_mode_field_o = 4'h0;
    compare_register_pair_o = 16'hFFFF;
    adc_enable_o = 1'b0;
    ext_clk_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // compare unit settings, changed just after an edge
  // ----------------------------------------------------------------
  task automatic set_cmp(input logic [3:0] mode, input logic [15:0] pair,
                         input logic adc);
    @(posedge sys_clk_i);
    compare_mode_field_o <= mode;
    compare_register_pair_o <= pair;
    adc_enable_o <= adc;
  endtask
  // ----------------------------------------------------------------
  // external count clock, still outside a burst
  // ----------------------------------------------------------------
  // edges stay aligned to the system clock so the edge detect counts each one once
  task automatic ext_burst(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      ext_clk_o <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      ext_clk_o <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
  endtask
endmodule

// [sim/tb_top.sv]
// self-checking bench for the sixteen bit timer
`timescale 1ns/100ps
module tb_top;
  import sbt_pkg::*;
  logic sys_clk, reset_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, mode;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic ext_clk, adc_en, osc_en, conv_req, irq;
  logic [15:0] pair;
  logic [31:0] d;
  int n_fail = 0;
  int total_checks = 0;
  int n_conv = 0;
  int c0;

  sbt_timer #(.ADDR_W(12), .INT_DIV(1)) DUT (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .ext_clk_i(ext_clk),
    .compare_mode_field_i(mode), .compare_register_pair_i(pair),
    .adc_enable_i(adc_en), .osc_enable_o(osc_en),
    .conv_request_o(conv_req), .irq_o(irq));

  sbt_far_model FAR (
    .sys_clk_i(sys_clk), .compare_mode_field_o(mode),
    .compare_register_pair_o(pair), .adc_enable_o(adc_en),
    .ext_clk_o(ext_clk));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (conv_req === 1'b1) n_conv <= n_conv + 1;
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] v,
                    input logic [1:0] rsp);
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // only the watchdog ends a wait for the response
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, rsp});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [1:0] rsp);
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, rsp});
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    rd(idx, RESP_OKAY);
    chk(d, {24'h000000, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(IDX_CONTROL, RESET_CONTROL);
    rdc(IDX_IRQ_FLAGS, 8'h00);
    rdc(IDX_IRQ_ENABLES, 8'h00);
    rdc(IDX_COUNT_LOW, 8'h00);
    chk({31'h0, osc_en}, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_map;
    wr(IDX_GLOBAL_IRQ, 8'hA5, RESP_OKAY);
    rdc(IDX_GLOBAL_IRQ, 8'hA5);
    rd(10'h3F0, RESP_SLVERR);
    chk(d, 32'h0);
    wr(10'h3F0, 8'h01, RESP_SLVERR);
    wr(IDX_IRQ_STATUS, 8'h01, RESP_SLVERR);
  endtask

  task automatic t_count_rw;
    wr(IDX_COUNT_LOW, 8'h34, RESP_OKAY);
    wr(IDX_COUNT_HIGH, 8'h12, RESP_OKAY);
    cyc(20);
    rdc(IDX_COUNT_LOW, 8'h34);
    rdc(IDX_COUNT_HIGH, 8'h12);
  endtask

  task automatic t_osc;
    wr(IDX_CONTROL, 8'hF8, RESP_OKAY);
    rdc(IDX_CONTROL, 8'h38);
    cyc(2);
    chk({31'h0, osc_en}, 32'h1);
    // software start-up delay, no ready indication exists
    cyc(200);
    wr(IDX_CONTROL, 8'h00, RESP_OKAY);
    cyc(2);
    chk({31'h0, osc_en}, 32'h0);
  endtask

  task automatic t_overflow;
    wr(IDX_COUNT_LOW, 8'hF0, RESP_OKAY);
    wr(IDX_COUNT_HIGH, 8'hFF, RESP_OKAY);
    wr(IDX_CONTROL, 8'h01, RESP_OKAY);
    cyc(40);
    wr(IDX_CONTROL, 8'h00, RESP_OKAY);
    rdc(IDX_COUNT_HIGH, 8'h00);
    rdc(IDX_IRQ_FLAGS, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_ENABLES, 8'h01, RESP_OKAY);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_ENABLES, 8'h00, RESP_OKAY);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    rdc(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_ENABLES, 8'h01, RESP_OKAY);
    wr(IDX_IRQ_CLEAR, 8'h01, RESP_OKAY);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    rdc(IDX_IRQ_STATUS, 8'h00);
  endtask

  task automatic t_trigger;
    wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
    wr(IDX_COUNT_HIGH, 8'h00, RESP_OKAY);
    FAR.set_cmp(CMP_MODE_SPECIAL, 16'h0010, 1'b1);
    c0 = n_conv;
    wr(IDX_CONTROL, 8'h01, RESP_OKAY);
    cyc(100);
    wr(IDX_CONTROL, 8'h00, RESP_OKAY);
    chk({31'h0, (n_conv - c0) >= 4}, 32'h1);
    rdc(IDX_COUNT_HIGH, 8'h00);
    rd(IDX_COUNT_LOW, RESP_OKAY);
    chk({31'h0, d <= 32'h10}, 32'h1);
    rdc(IDX_IRQ_FLAGS, 8'h00);
    FAR.set_cmp(CMP_MODE_SPECIAL, 16'h0010, 1'b0);
    c0 = n_conv;
    wr(IDX_CONTROL, 8'h01, RESP_OKAY);
    cyc(60);
    wr(IDX_CONTROL, 8'h00, RESP_OKAY);
    chk(n_conv - c0, 32'h0);
  endtask

  task automatic t_write_wins;
    // pair equal to a stopped count keeps the clear asserted every cycle
    FAR.set_cmp(CMP_MODE_SPECIAL, 16'h0000, 1'b0);
    wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
    wr(IDX_COUNT_HIGH, 8'h00, RESP_OKAY);
    wr(IDX_COUNT_LOW, 8'h55, RESP_OKAY);
    cyc(5);
    rdc(IDX_COUNT_LOW, 8'h55);
  endtask

  task automatic t_unsync;
    FAR.set_cmp(CMP_MODE_SPECIAL, 16'h0020, 1'b1);
    wr(IDX_CONTROL, 8'h06, RESP_OKAY);
    c0 = n_conv;
    wr(IDX_COUNT_LOW, 8'h20, RESP_OKAY);
    cyc(10);
    chk({31'h0, n_conv > c0}, 32'h1);
    rdc(IDX_COUNT_LOW, 8'h20);
  endtask

  task automatic t_ext;
    FAR.set_cmp(4'h0, 16'hFFFF, 1'b0);
    wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
    wr(IDX_CONTROL, 8'h03, RESP_OKAY);
    FAR.ext_burst(5);
    cyc(4);
    wr(IDX_CONTROL, 8'h00, RESP_OKAY);
    rdc(IDX_COUNT_LOW, 8'h05);
  endtask

  task automatic t_prescale;
    // one count per eight source pulses; the stop falls between two ticks
    wr(IDX_COUNT_LOW, 8'h00, RESP_OKAY);
    wr(IDX_CONTROL, 8'h31, RESP_OKAY);
    cyc(80);
    wr(IDX_CONTROL, 8'h00, RESP_OKAY);
    rdc(IDX_COUNT_LOW, 8'h0A);
  endtask

  task automatic t_rereset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    rdc(IDX_COUNT_LOW, 8'h00);
    rdc(IDX_CONTROL, RESET_CONTROL);
    rdc(IDX_GLOBAL_IRQ, RESET_GLOBAL);
  endtask

  task automatic conclude;
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_map();
    t_count_rw();
    t_osc();
    t_overflow();
    t_trigger();
    t_write_wins();
    t_unsync();
    t_ext();
    t_prescale();
    t_rereset();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule
